// [hdl/rx_alarm_pkg.sv]
package rx_alarm_pkg;

   // --------
   // Register map (byte addresses on APB)
   // --------
   localparam logic [11:0] ADDR_LIVE_1 = 12'h000;
   localparam logic [11:0] ADDR_STICKY_1 = 12'h004;
   localparam logic [11:0] ADDR_MASK_1 = 12'h008;
   localparam logic [11:0] ADDR_TX_CTRL_2 = 12'h00C;
   localparam logic [11:0] ADDR_T1_CTRL_2 = 12'h010;
   localparam logic [11:0] ADDR_BOC_CTRL = 12'h014;

   // --------
   // Field positions
   // --------
   localparam int LIVE_FRAME_LOSS = 0;
   localparam int LIVE_SIGNAL_LOSS = 1;
   localparam int LIVE_BLUE = 2;
   localparam int LIVE_YELLOW = 3;
   localparam int ST_FRAME_LOST = 0;
   localparam int ST_SIGNAL_LOSS = 1;
   localparam int ST_BLUE = 2;
   localparam int ST_YELLOW = 3;
   localparam int ST_FRAME_REGAINED = 4;
   localparam int ST_BLUE_CI = 5;
   localparam int ST_YELLOW_CI = 6;
   localparam int TXC_AUTO_RAI = 5;
   localparam int TXC_AUTO_AIS = 6;
   localparam int T1C_YEL_SEL = 0;
   localparam int T1C_ESF_INTEG = 1;
   localparam int T1C_ESF_MODE = 2;
   localparam int T1C_CRC4_EN = 3;
   localparam int STICKY_W = 7;

   // --------
   // Reset values
   // --------
   localparam logic [7:0] MASK_RESET = 8'h00;
   localparam logic [7:0] CTRL_RESET = 8'h00;

   // --------
   // Detector figures and times
   // --------
   localparam int CLK_MHZ = 125;
   localparam int BLUE_WIN_US = 3000;
   localparam int BLUE_WIN_CYC = BLUE_WIN_US * CLK_MHZ;
   localparam int BLUE_SET_MAX_ZEROS = 4;
   localparam int Y_D4_CHANS = 256;
   localparam int Y_D4_MIN_ZEROS = 254;
   localparam int Y_ESF_SET = 16;
   localparam int Y_ESF_CLR_MAX = 14;
   localparam logic [15:0] Y_ESF_PATTERN = 16'h00FF;
   localparam logic [15:0] RAI_CI_CODE = 16'h3EFF;
   localparam int LOS_ZEROS = 192;
   localparam int LOS_ONES = 14;
   localparam int LOS_SPAN = 112;
   localparam int CI_LEN = 6176;
   localparam int CI_Z0 = 3088;
   localparam int CI_Z1 = 3474;
   localparam int CI_Z2 = 5790;
   localparam int CRC4_WAIT_US = 128000;
   localparam int CRC4_WAIT_CYC = CRC4_WAIT_US * CLK_MHZ;
   localparam int AIS_CI_REP_US = 1200000;
   localparam int AIS_CI_REP_CYC = AIS_CI_REP_US * CLK_MHZ;
   localparam int RAI_CI_REP_US = 1100000;
   localparam int RAI_CI_REP_CYC = RAI_CI_REP_US * CLK_MHZ;

endpackage : rx_alarm_pkg

// [hdl/rx_alarm_status_irq.sv]
// The APB interface to the registers and the register addresses are this design's own decisions.
module rx_alarm_status_irq
   import rx_alarm_pkg::*;
#(
   parameter int BLUE_WIN = BLUE_WIN_CYC,       // Blue alarm window in clocks.
   parameter int CRC4_WAIT = CRC4_WAIT_CYC,     // CRC-4 lock wait in clocks.
   parameter int AIS_CI_REP = AIS_CI_REP_CYC,   // AIS-CI re-set period in clocks.
   parameter int RAI_CI_REP = RAI_CI_REP_CYC    // RAI-CI re-set period in clocks.
)
(
   input wire logic sys_clk_in,               // System clock, 125 MHz.
   input wire logic rst_in,                   // Asynchronous reset, active high.
   input wire logic psel_in,                  // APB select.
   input wire logic penable_in,               // APB enable.
   input wire logic pwrite_in,                // APB write.
   input wire logic [11:0] paddr_in,          // APB byte address.
   input wire logic [31:0] pwdata_in,         // APB write data.
   output logic [31:0] prdata_out,            // APB read data.
   output logic pready_out,                   // APB ready.
   output logic pslverr_out,                  // APB error on unmapped address.
   input wire logic rx_bit_valid_in,          // One received bit this cycle.
   input wire logic rx_bit_in,                // Received line bit.
   input wire logic rx_frame_loss_in,         // Synchronizer out of frame.
   input wire logic fas_lock_in,              // E1 FAS alignment found.
   input wire logic crc4_lock_in,             // E1 CRC-4 multiframe found.
   input wire logic ch_bit2_valid_in,         // Channel bit 2 sample strobe.
   input wire logic ch_bit2_in,               // Channel bit 2 value.
   input wire logic fbit12_valid_in,          // 12th F-bit sample strobe.
   input wire logic fbit12_in,                // 12th F-bit value.
   input wire logic fdl_valid_in,             // FDL bit strobe.
   input wire logic fdl_bit_in,               // FDL bit value.
   input wire logic esf_integ_tick_in,        // 200 ms integration qualifier.
   output logic irq_out_n,                    // Interrupt, active low.
   output logic tx_force_ais_out,             // Transmit AIS now.
   output logic tx_force_rai_out              // Transmit RAI now.
);

   initial
   begin
      if (BLUE_WIN < 1 || CRC4_WAIT < 1 || AIS_CI_REP < 1 || RAI_CI_REP < 1)
         $error("rx_alarm_status_irq: counts must be at least one");
   end

   // --------
   // State
   // --------
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic irq_n;
      logic ais;
      logic rai;
      logic [STICKY_W-1:0] sticky;
      logic [STICKY_W-1:0] mask;
      logic [7:0] tx_ctrl;
      logic [7:0] t1_ctrl;
      logic [7:0] boc_ctrl;
      logic lof_d;
      logic los_d;
      logic blue_d;
      logic yel_d;
      logic blue;
      logic yellow;
      logic los;
      logic [31:0] blue_cnt;
      logic [2:0] blue_zeros;
      logic [8:0] ch_cnt;
      logic [8:0] ch_zeros;
      logic [1:0] f12_hist;
      logic [15:0] fdl_sh;
      logic [3:0] fdl_bitc;
      logic [4:0] pat_cnt;
      logic [4:0] pat_hits;
      logic [7:0] zrun;
      logic los_clr_act;
      logic [6:0] los_span;
      logic [3:0] los_ones;
      logic [12:0] ci_pos;
      logic ci_ok;
      logic ci_seen;
      logic [31:0] ais_ci_cnt;
      logic [31:0] rai_ci_cnt;
      logic [2:0] boc_cnt;
      logic [31:0] crc4_cnt;
      logic crc4_fail;
   } state_t;

   state_t s_r;
   state_t s_nxt;

   logic wr;
   logic rd;
   logic [STICKY_W-1:0] ev;
   logic mapped;
   logic boc_hit;
   logic [2:0] boc_need;

   // --------
   // Next state
   // --------
   // All detectors, the register file and the outputs are one
   // combinational pass; every output is then registered.
   always_comb
   begin
      s_nxt = s_r;
      ev = '0;
      wr = psel_in && penable_in && pwrite_in && s_r.pready;
      rd = psel_in && !penable_in && !pwrite_in;
      mapped = (paddr_in == ADDR_LIVE_1) || (paddr_in == ADDR_STICKY_1) || (paddr_in == ADDR_MASK_1) ||
               (paddr_in == ADDR_TX_CTRL_2) || (paddr_in == ADDR_T1_CTRL_2) || (paddr_in == ADDR_BOC_CTRL);
      boc_hit = 1'b0;
      boc_need = 3'd1 + {1'b0, s_r.boc_ctrl[1:0]};

      // Received-bit detectors: blue alarm, signal loss, AIS-CI.
      if (rx_bit_valid_in)
      begin
         // Blue alarm judged once per window on its zero count.
         if (!rx_bit_in && s_r.blue_zeros <= 3'(BLUE_SET_MAX_ZEROS))
            s_nxt.blue_zeros = s_r.blue_zeros + 3'd1;
         // Signal loss on a run of zeros.
         if (rx_bit_in)
            s_nxt.zrun = '0;
         else if (s_r.zrun < 8'(LOS_ZEROS))
            s_nxt.zrun = s_r.zrun + 8'd1;
         if (!rx_bit_in && s_r.zrun == 8'(LOS_ZEROS - 1))
            s_nxt.los = 1'b1;
         // Clearing window starts at the first one while in loss.
         if (s_r.los && !s_r.los_clr_act && rx_bit_in)
         begin
            s_nxt.los_clr_act = 1'b1;
            s_nxt.los_span = 7'd1;
            s_nxt.los_ones = 4'd1;
         end
         else if (s_r.los_clr_act)
         begin
            s_nxt.los_span = s_r.los_span + 7'd1;
            if (rx_bit_in)
               s_nxt.los_ones = s_r.los_ones + 4'd1;
            if (rx_bit_in && s_r.los_ones == 4'(LOS_ONES - 1))
            begin
               s_nxt.los = 1'b0;
               s_nxt.los_clr_act = 1'b0;
            end
            else if (s_r.los_span == 7'(LOS_SPAN))
               s_nxt.los_clr_act = 1'b0;
         end
         // AIS-CI signature: zeros only at the three marked positions.
         if (((s_r.ci_pos == 13'(CI_Z0)) || (s_r.ci_pos == 13'(CI_Z1)) || (s_r.ci_pos == 13'(CI_Z2))) == rx_bit_in)
            s_nxt.ci_ok = 1'b0;
         if (s_r.ci_pos == 13'(CI_LEN - 1))
         begin
            s_nxt.ci_pos = '0;
            s_nxt.ci_seen = s_r.ci_ok && (((s_r.ci_pos == 13'(CI_Z2))) != rx_bit_in);
            s_nxt.ci_ok = 1'b1;
         end
         else
            s_nxt.ci_pos = s_r.ci_pos + 13'd1;
         // Resynchronise the signature phase: a zero seen while out of step is taken as the first mark.
         if (!rx_bit_in && !s_r.ci_ok && s_r.ci_pos != 13'(CI_Z0))
         begin
            s_nxt.ci_pos = 13'(CI_Z0 + 1);
            s_nxt.ci_ok = 1'b1;
         end
      end
      if (s_r.blue_cnt == 32'(BLUE_WIN - 1))
      begin
         s_nxt.blue_cnt = '0;
         s_nxt.blue = s_nxt.blue_zeros <= 3'(BLUE_SET_MAX_ZEROS);
         s_nxt.blue_zeros = '0;
      end
      else
         s_nxt.blue_cnt = s_r.blue_cnt + 32'd1;

      // D4 bit-2 yellow alarm over blocks of 256 channels.
      if (!s_r.t1_ctrl[T1C_ESF_MODE] && !s_r.t1_ctrl[T1C_YEL_SEL] && ch_bit2_valid_in)
      begin
         if (s_r.ch_cnt == 9'(Y_D4_CHANS - 1))
         begin
            s_nxt.yellow = (s_r.ch_zeros + {8'd0, !ch_bit2_in}) >= 9'(Y_D4_MIN_ZEROS);
            s_nxt.ch_cnt = '0;
            s_nxt.ch_zeros = '0;
         end
         else
         begin
            s_nxt.ch_cnt = s_r.ch_cnt + 9'd1;
            s_nxt.ch_zeros = s_r.ch_zeros + {8'd0, !ch_bit2_in};
         end
      end
      // D4 12th F-bit yellow alarm on two equal occurrences.
      if (!s_r.t1_ctrl[T1C_ESF_MODE] && s_r.t1_ctrl[T1C_YEL_SEL] && fbit12_valid_in)
      begin
         s_nxt.f12_hist = {s_r.f12_hist[0], fbit12_in};
         if (s_r.f12_hist[0] && fbit12_in)
            s_nxt.yellow = 1'b1;
         else if (!s_r.f12_hist[0] && !fbit12_in)
            s_nxt.yellow = 1'b0;
      end
      // ESF data link: 00FF count and bit-oriented codes.
      if (fdl_valid_in)
      begin
         s_nxt.fdl_sh = {fdl_bit_in, s_r.fdl_sh[15:1]};
         s_nxt.fdl_bitc = s_r.fdl_bitc + 4'd1;
         if (s_r.fdl_bitc == 4'd15)
         begin
            boc_hit = s_nxt.fdl_sh == RAI_CI_CODE;
            if (s_r.t1_ctrl[T1C_ESF_MODE] && (!s_r.t1_ctrl[T1C_ESF_INTEG] || esf_integ_tick_in || s_r.yellow))
            begin
               s_nxt.pat_hits = s_r.pat_hits + {4'd0, s_nxt.fdl_sh == Y_ESF_PATTERN};
               if (s_nxt.fdl_sh == Y_ESF_PATTERN && s_r.pat_hits == s_r.pat_cnt &&
                   s_r.pat_cnt == 5'(Y_ESF_SET - 1))
                  s_nxt.yellow = 1'b1;
               if (s_r.pat_cnt == 5'(Y_ESF_SET - 1))
               begin
                  if (s_nxt.pat_hits <= 5'(Y_ESF_CLR_MAX))
                     s_nxt.yellow = 1'b0;
                  s_nxt.pat_cnt = '0;
                  s_nxt.pat_hits = '0;
               end
               else
                  s_nxt.pat_cnt = s_r.pat_cnt + 5'd1;
            end
            // The BOC filter asks for 1 to 4 identical codes in a row, set by boc_ctrl.
            if (boc_hit)
               s_nxt.boc_cnt = (s_r.boc_cnt < boc_need) ? s_r.boc_cnt + 3'd1 : s_r.boc_cnt;
            else
               s_nxt.boc_cnt = '0;
         end
      end

      // CRC-4 multiframe lock watchdog after FAS lock.
      if (!fas_lock_in || crc4_lock_in || !s_r.t1_ctrl[T1C_CRC4_EN])
      begin
         s_nxt.crc4_cnt = '0;
         s_nxt.crc4_fail = 1'b0;
      end
      else if (s_r.crc4_cnt == 32'(CRC4_WAIT - 1))
         s_nxt.crc4_fail = 1'b1;
      else
         s_nxt.crc4_cnt = s_r.crc4_cnt + 32'd1;

      // Event pulses from edges of the live conditions.
      s_nxt.lof_d = rx_frame_loss_in;
      s_nxt.los_d = s_r.los;
      s_nxt.blue_d = s_r.blue;
      s_nxt.yel_d = s_r.yellow;
      ev[ST_FRAME_LOST] = rx_frame_loss_in && !s_r.lof_d;
      ev[ST_FRAME_REGAINED] = !rx_frame_loss_in && s_r.lof_d;
      ev[ST_SIGNAL_LOSS] = s_r.los && !s_r.los_d;
      ev[ST_BLUE] = s_r.blue && !s_r.blue_d;
      ev[ST_YELLOW] = s_r.yellow && !s_r.yel_d;

      // CI indications repeat on their own timers while present.
      if (s_r.ci_seen && s_r.blue && (s_r.ais_ci_cnt == '0))
         ev[ST_BLUE_CI] = 1'b1;
      if (s_r.blue && s_r.ci_seen)
         s_nxt.ais_ci_cnt = (s_r.ais_ci_cnt == 32'(AIS_CI_REP - 1)) ? '0 : s_r.ais_ci_cnt + 32'd1;
      else
         s_nxt.ais_ci_cnt = '0;
      if (s_r.yellow && s_r.boc_cnt >= boc_need)
      begin
         ev[ST_YELLOW_CI] = s_r.rai_ci_cnt == '0;
         s_nxt.rai_ci_cnt = (s_r.rai_ci_cnt == 32'(RAI_CI_REP - 1)) ? '0 : s_r.rai_ci_cnt + 32'd1;
      end
      else
         s_nxt.rai_ci_cnt = '0;

      // Register writes; a new event wins over a clear in the same cycle.
      s_nxt.pready = psel_in && !penable_in;
      s_nxt.pslverr = psel_in && !penable_in && !mapped;
      if (wr && paddr_in == ADDR_STICKY_1)
         s_nxt.sticky = s_r.sticky & ~pwdata_in[STICKY_W-1:0];
      s_nxt.sticky = s_nxt.sticky | ev;
      if (wr && paddr_in == ADDR_MASK_1)
         s_nxt.mask = pwdata_in[STICKY_W-1:0];
      if (wr && paddr_in == ADDR_TX_CTRL_2)
         s_nxt.tx_ctrl = pwdata_in[7:0];
      if (wr && paddr_in == ADDR_T1_CTRL_2)
         s_nxt.t1_ctrl = pwdata_in[7:0];
      if (wr && paddr_in == ADDR_BOC_CTRL)
         s_nxt.boc_ctrl = pwdata_in[7:0];

      // Read data captured in setup; reads have no side effects.
      s_nxt.prdata = '0;
      if (rd)
      begin
         unique case (paddr_in)
            ADDR_LIVE_1: s_nxt.prdata = {28'd0, s_r.yellow, s_r.blue, s_r.los, rx_frame_loss_in};
            ADDR_STICKY_1: s_nxt.prdata = {25'd0, s_r.sticky};
            ADDR_MASK_1: s_nxt.prdata = {25'd0, s_r.mask};
            ADDR_TX_CTRL_2: s_nxt.prdata = {24'd0, s_r.tx_ctrl};
            ADDR_T1_CTRL_2: s_nxt.prdata = {24'd0, s_r.t1_ctrl};
            ADDR_BOC_CTRL: s_nxt.prdata = {24'd0, s_r.boc_ctrl};
            default: s_nxt.prdata = '0;
         endcase
      end
      else if (psel_in && penable_in)
         s_nxt.prdata = s_r.prdata;

      // Interrupt and automatic transmit alarms.
      s_nxt.irq_n = ~|(s_nxt.sticky & s_nxt.mask);
      s_nxt.ais = s_r.tx_ctrl[TXC_AUTO_AIS] && (rx_frame_loss_in || s_r.blue || s_r.los);
      s_nxt.rai = s_r.tx_ctrl[TXC_AUTO_RAI] &&
                  (rx_frame_loss_in || s_r.blue || s_r.los || s_r.crc4_fail);
   end

   // --------
   // State register
   // --------
   always_ff @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         s_r <= '0;
         s_r.irq_n <= 1'b1;
         s_r.mask <= MASK_RESET[STICKY_W-1:0];
         s_r.tx_ctrl <= CTRL_RESET;
         s_r.t1_ctrl <= CTRL_RESET;
         s_r.boc_ctrl <= CTRL_RESET;
         s_r.ci_ok <= 1'b1;
      end
      else
         s_r <= s_nxt;
   end

   assign prdata_out = s_r.prdata;
   assign pready_out = s_r.pready;
   assign pslverr_out = s_r.pslverr;
   assign irq_out_n = s_r.irq_n;
   assign tx_force_ais_out = s_r.ais;
   assign tx_force_rai_out = s_r.rai;

endmodule : rx_alarm_status_irq

// [verification/rx_host_model.sv]
module rx_host_model
   import rx_alarm_pkg::*;
(
   input wire logic sys_clk_in, // Clock.
   output logic psel_out, // Select.
   output logic penable_out, // Enable.
   output logic pwrite_out, // Write.
   output logic [11:0] paddr_out, // Address.
   output logic [31:0] pwdata_out, // Write data.
   input wire logic [31:0] prdata_in, // Read data.
   input wire logic pready_in, // Ready.
   input wire logic pslverr_in // Error.
);
   logic hung = 1'b0;
   // The bus idles low from time zero.
   initial
   begin
      {psel_out, penable_out, pwrite_out, paddr_out, pwdata_out} = '0;
   end
   // One transfer; the request stands until ready is sampled high or 32 clocks pass, then one idle clock.
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] v,
                       output logic e);
      int n;
      n = 0;
      psel_out <= 1'b1;
      pwrite_out <= w;
      paddr_out <= a;
      pwdata_out <= d;
      @(posedge sys_clk_in);
      penable_out <= 1'b1;
      do
      begin
         @(posedge sys_clk_in);
         n++;
      end
      while (pready_in !== 1'b1 && n < 32);
      hung = (pready_in !== 1'b1);
      v = prdata_in;
      e = pslverr_in;
      psel_out <= 1'b0;
      penable_out <= 1'b0;
      @(posedge sys_clk_in);
   endtask : xfer
   // Read first, then write ones only where a set bit is meant to be cleared.
   task automatic clear(input logic [31:0] bits);
      logic [31:0] v;
      logic e;
      xfer(1'b0, ADDR_STICKY_1, 32'h0, v, e);
      xfer(1'b1, ADDR_STICKY_1, v & bits, v, e);
   endtask : clear
   // A control word enabling both automatic alarms is never sent.
   task automatic set_tx(input logic [7:0] c);
      logic [31:0] v;
      logic e;
      if (!(c[TXC_AUTO_AIS] && c[TXC_AUTO_RAI]))
         xfer(1'b1, ADDR_TX_CTRL_2, {24'h0, c}, v, e);
   endtask : set_tx
endmodule : rx_host_model

// [verification/rx_alarm_status_irq_checker.sv]
module rx_alarm_status_irq_checker
   import rx_alarm_pkg::*;
(
   input wire logic sys_clk_in, // Clock.
   input wire logic rst_in, // Reset.
   input wire logic psel_in, // Select.
   input wire logic penable_in, // Enable.
   input wire logic pwrite_in, // Write.
   input wire logic [11:0] paddr_in, // Address.
   input wire logic [31:0] pwdata_in, // Write data.
   input wire logic pready_out, // Ready.
   input wire logic pslverr_out, // Error.
   input wire logic rx_frame_loss_in, // Frame loss.
   input wire logic irq_out_n, // Interrupt.
   input wire logic tx_force_ais_out, // AIS force.
   input wire logic tx_force_rai_out // RAI force.
);
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (rst_in);
   logic [7:0] mask_r;
   logic [7:0] txc_r;
   logic [2:0] wr_r;
   logic [3:0] lof_r;
   logic acc_wr;
   logic quiet;
   // Shadows of the mask and transmit control, since the checker cannot look inside.
   assign acc_wr = psel_in && penable_in && pready_out && pwrite_in;
   assign quiet = (lof_r == {4{rx_frame_loss_in}});
   always_ff @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         mask_r <= MASK_RESET;
         txc_r <= CTRL_RESET;
         wr_r <= 3'h0;
         lof_r <= 4'h0;
      end
      else
      begin
         mask_r <= (acc_wr && paddr_in == ADDR_MASK_1) ? pwdata_in[7:0] : mask_r;
         txc_r <= (acc_wr && paddr_in == ADDR_TX_CTRL_2) ? pwdata_in[7:0] : txc_r;
         wr_r <= {wr_r[1:0], psel_in && pwrite_in};
         lof_r <= {lof_r[2:0], rx_frame_loss_in};
      end
   end
   // Bus answers with no wait state and flags only unmapped addresses.
   property p_zero_wait; psel_in && !penable_in |=> pready_out; endproperty
   a_zero_wait: assert property (p_zero_wait) else $error("ready missing in access cycle");
   property p_slverr; pready_out |-> pslverr_out == (paddr_in > ADDR_BOC_CTRL); endproperty
   a_slverr: assert property (p_slverr) else $error("error flag wrong for address");
   // Forced alarms follow frame loss within three clocks; AIS drops once disabled.
   property p_ais_on; txc_r[TXC_AUTO_AIS] && rx_frame_loss_in |-> ##[1:3] tx_force_ais_out; endproperty
   a_ais_on: assert property (p_ais_on) else $error("AIS not forced on frame loss");
   property p_ais_off; !txc_r[TXC_AUTO_AIS] [*3] |-> !tx_force_ais_out; endproperty
   a_ais_off: assert property (p_ais_off) else $error("AIS forced while disabled");
   property p_rai_on; txc_r[TXC_AUTO_RAI] && rx_frame_loss_in |-> ##[1:3] tx_force_rai_out; endproperty
   a_rai_on: assert property (p_rai_on) else $error("RAI not forced on frame loss");
   // Interrupt follows unmasked sticky events and holds until a write.
   property p_masked; mask_r == 8'h00 [*3] |-> irq_out_n; endproperty
   a_masked: assert property (p_masked) else $error("interrupt low with all events masked");
   property p_lof_irq; mask_r[ST_FRAME_LOST] && $rose(rx_frame_loss_in) |-> ##[1:4] !irq_out_n; endproperty
   a_lof_irq: assert property (p_lof_irq) else $error("no interrupt on frame loss");
   property p_irq_hold; !irq_out_n && wr_r == 3'h0 && !(psel_in && pwrite_in) |=> !irq_out_n; endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("interrupt released without a write");
   sequence s_clear_lost;
      acc_wr && paddr_in == ADDR_STICKY_1 && pwdata_in[ST_FRAME_LOST] && mask_r == 8'h01 && quiet;
   endsequence
   sequence s_no_new_loss; quiet [*3]; endsequence
   property p_irq_release; s_clear_lost ##1 s_no_new_loss |-> irq_out_n; endproperty
   a_irq_release: assert property (p_irq_release) else $error("interrupt kept after clear");
endmodule : rx_alarm_status_irq_checker
bind rx_alarm_status_irq rx_alarm_status_irq_checker rx_alarm_status_irq_checker_inst (.*);

// [verification/rx_alarm_status_irq_tb.sv]
module rx_alarm_status_irq_tb
   import rx_alarm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic psel, penable, pwrite, pready, pslverr, irq_n, ais, rai;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic bit_v = 1'b0, bit_d = 1'b0, lof = 1'b0, fb_v = 1'b0, fb_d = 1'b0, ch_v = 1'b0, ch_d = 1'b0;
   logic fas = 1'b0, crc = 1'b0, fv = 1'b0, fd = 1'b0, tick = 1'b0;
   int failures = 0;
   int checked = 0;
   // Clock at 125 MHz.
   always #4 sys_clk_in = ~sys_clk_in;
   rx_alarm_status_irq #(.BLUE_WIN(64), .CRC4_WAIT(32), .AIS_CI_REP(100), .RAI_CI_REP(100)) rx_alarm_status_irq_inst (
      .sys_clk_in(sys_clk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
      .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
      .rx_bit_valid_in(bit_v), .rx_bit_in(bit_d), .rx_frame_loss_in(lof), .fas_lock_in(fas), .crc4_lock_in(crc),
      .ch_bit2_valid_in(ch_v), .ch_bit2_in(ch_d), .fbit12_valid_in(fb_v), .fbit12_in(fb_d), .fdl_valid_in(fv),
      .fdl_bit_in(fd), .esf_integ_tick_in(tick), .irq_out_n(irq_n), .tx_force_ais_out(ais), .tx_force_rai_out(rai));
   rx_host_model rx_host_model_inst (.sys_clk_in(sys_clk_in), .psel_out(psel), .penable_out(penable),
      .pwrite_out(pwrite), .paddr_out(paddr), .pwdata_out(pwdata), .prdata_in(prdata), .pready_in(pready),
      .pslverr_in(pslverr));
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp)
      begin
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
         failures++;
      end
   endtask : check
   task automatic end_of_test();
      $display("checked %0d, failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_of_test
   task automatic step(input int n);
      repeat (n) @(posedge sys_clk_in);
   endtask : step
   // A transfer that never completes counts as a mismatch and ends the run.
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] v,
                       output logic e);
      rx_host_model_inst.xfer(w, a, d, v, e);
      if (rx_host_model_inst.hung)
      begin
         failures++;
         end_of_test();
      end
   endtask : xfer
   task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x, input string what);
      logic [31:0] v;
      logic e;
      xfer(1'b0, a, 32'h0, v, e);
      check(what, x, v & m);
   endtask : rd
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] v;
      logic e;
      xfer(1'b1, a, d, v, e);
   endtask : wr
   // Strobes n samples of one value: k 0 line bits, 1 channel bit 2, 2 twelfth F-bit.
   task automatic feed(input int k, input logic b, input int n);
      {bit_v, ch_v, fb_v} <= 3'b100 >> k;
      {bit_d, ch_d, fb_d} <= {3{b}};
      step(n);
      {bit_v, ch_v, fb_v} <= 3'b000;
      step(1);
   endtask : feed
   // Reset values, an unmapped access and the idle interrupt level.
   task automatic t_reset();
      logic [31:0] v;
      logic e;
      rd(ADDR_MASK_1, 32'hFF, {24'h0, MASK_RESET}, "mask");
      rd(ADDR_TX_CTRL_2, 32'hFF, {24'h0, CTRL_RESET}, "tx control");
      rd(ADDR_T1_CTRL_2, 32'hFF, {24'h0, CTRL_RESET}, "t1 control");
      rd(ADDR_STICKY_1, 32'h11, 32'h0, "sticky");
      xfer(1'b0, 12'h018, 32'h0, v, e);
      check("unmapped error", 32'h1, {31'h0, e});
      check("unmapped data", 32'h0, v);
      check("idle interrupt", 32'h1, {31'h0, irq_n});
   endtask : t_reset
   // Frame loss edges, clearing by one and the no-reset while lost.
   task automatic t_frame();
      lof <= 1'b1;
      step(3);
      wr(ADDR_LIVE_1, 32'h0);
      rd(ADDR_LIVE_1, 32'h1, 32'h1, "live frame loss");
      rd(ADDR_STICKY_1, 32'h11, 32'h1, "frame lost");
      wr(ADDR_STICKY_1, 32'h0);
      rd(ADDR_STICKY_1, 32'h11, 32'h1, "frame lost after zero write");
      rx_host_model_inst.clear(32'h1);
      rd(ADDR_STICKY_1, 32'h11, 32'h0, "frame lost cleared");
      step(20);
      rd(ADDR_STICKY_1, 32'h11, 32'h0, "frame lost while still lost");
      lof <= 1'b0;
      step(3);
      rd(ADDR_STICKY_1, 32'h11, 32'h10, "frame regained");
      rx_host_model_inst.clear(32'h11);
   endtask : t_frame
   // Interrupt masking, release by clear while lost, and a new occurrence.
   task automatic t_irq();
      lof <= 1'b1;
      step(4);
      check("masked interrupt", 32'h1, {31'h0, irq_n});
      wr(ADDR_MASK_1, 32'h1);
      step(3);
      check("unmasked interrupt", 32'h0, {31'h0, irq_n});
      rx_host_model_inst.clear(32'h1);
      step(3);
      check("interrupt after clear", 32'h1, {31'h0, irq_n});
      lof <= 1'b0;
      step(2);
      lof <= 1'b1;
      step(4);
      check("interrupt on new loss", 32'h0, {31'h0, irq_n});
      wr(ADDR_MASK_1, 32'h0);
      rx_host_model_inst.clear(32'h7F);
   endtask : t_irq
   // Automatic alarms with frame loss present, one enable at a time.
   task automatic t_auto();
      rx_host_model_inst.set_tx(8'h40);
      step(3);
      check("auto AIS", 32'h1, {31'h0, ais});
      check("no RAI", 32'h0, {31'h0, rai});
      rx_host_model_inst.set_tx(8'h20);
      step(3);
      check("auto RAI", 32'h1, {31'h0, rai});
      check("AIS off", 32'h0, {31'h0, ais});
      rx_host_model_inst.set_tx(8'h00);
      lof <= 1'b0;
      step(3);
      check("RAI off", 32'h0, {31'h0, rai});
   endtask : t_auto
   // Twelfth F-bit mode, then bit-2 mode at the 254 of 256 boundary.
   task automatic t_yellow();
      wr(ADDR_T1_CTRL_2, 32'h1);
      feed(2, 1'b1, 1);
      rd(ADDR_LIVE_1, 32'h8, 32'h0, "yellow after one");
      feed(2, 1'b1, 1);
      rd(ADDR_LIVE_1, 32'h8, 32'h8, "yellow after two");
      feed(2, 1'b0, 1);
      rd(ADDR_LIVE_1, 32'h8, 32'h8, "yellow after one zero");
      feed(2, 1'b0, 1);
      rd(ADDR_LIVE_1, 32'h8, 32'h0, "yellow after two zeros");
      wr(ADDR_T1_CTRL_2, 32'h0);
      feed(1, 1'b0, 256);
      rd(ADDR_LIVE_1, 32'h8, 32'h8, "bit 2 yellow set");
      feed(1, 1'b1, 3);
      feed(1, 1'b0, 253);
      rd(ADDR_LIVE_1, 32'h8, 32'h0, "bit 2 yellow clear");
   endtask : t_yellow
   // Signal loss at exactly 192 zeros, blue alarm windows, alarms forced by them.
   task automatic t_line();
      feed(0, 1'b1, 8);
      feed(0, 1'b0, 191);
      rd(ADDR_LIVE_1, 32'h2, 32'h0, "loss at 191 zeros");
      feed(0, 1'b0, 1);
      step(2);
      rd(ADDR_LIVE_1, 32'h2, 32'h2, "loss at 192 zeros");
      feed(0, 1'b1, 13);
      rd(ADDR_LIVE_1, 32'h2, 32'h2, "loss at 13 ones");
      feed(0, 1'b1, 1);
      step(2);
      rd(ADDR_LIVE_1, 32'h2, 32'h0, "loss at 14 ones");
      feed(0, 1'b1, 192);
      rd(ADDR_LIVE_1, 32'h5, 32'h4, "blue on all ones");
      feed(0, 1'b0, 4);
      feed(0, 1'b1, 140);
      rd(ADDR_LIVE_1, 32'h4, 32'h4, "blue with four zeros");
      rx_host_model_inst.set_tx(8'h40);
      step(3);
      check("AIS on blue alarm", 32'h1, {31'h0, ais});
      rx_host_model_inst.set_tx(8'h00);
      feed(0, 1'b0, 200);
      step(2);
      rd(ADDR_LIVE_1, 32'h6, 32'h2, "blue clear, loss set");
      rx_host_model_inst.set_tx(8'h20);
      step(3);
      check("RAI on carrier loss", 32'h1, {31'h0, rai});
      rx_host_model_inst.set_tx(8'h00);
   endtask : t_line
   // Main sequence after 16 clocks of reset.
   initial
   begin
      step(16);
      rst_in <= 1'b0;
      step(1);
      t_reset();
      t_frame();
      t_irq();
      t_auto();
      t_yellow();
      t_line();
      end_of_test();
   end
endmodule : rx_alarm_status_irq_tb
